// >>> verification/dbs_ctrl_model.sv
// Memory controller model: makes the link clocks, loads bursts and moves their beats.
`timescale 1ns/1ps
module dbs_ctrl_model (
  input wire logic tied,
  output logic kClk,
  output logic kClkN,
  output logic cClk,
  output logic cClkN,
  output dbs_pkg::dbs_cmd_s linkCmd,
  output logic [7:0] linkAddr,
  output logic [35:0] dqIn,
  input wire logic [35:0] dqOut
);
  import dbs_pkg::*;
  logic cRef;
  // K runs freely and tied C clocks sit high together, so the link clocks never rest at mismatched levels.
  initial begin
    kClk = 1'b0;
    cRef = 1'b0;
    linkCmd = '{1'b1, 1'b0, 4'hf};
    linkAddr = 8'h0;
    dqIn = 36'h0;
    #3;
    forever #80 kClk = ~kClk;
  end
  always @(kClk) cRef <= #20 kClk;
  assign kClkN = ~kClk;
  assign cClk = tied | cRef;
  assign cClkN = tied | ~cRef;
  // Read beats are sampled mid-beat, since they move on the very edges that launch them.
  task automatic burst(input logic rw, input logic lateN, input logic [7:0] a, input logic [35:0] d[4],
    input logic [3:0] m[4], output logic [35:0] q[4]);
    repeat (4) @(posedge kClk);
    linkCmd <= '{1'b0, rw, 4'hf};
    linkAddr <= a;
    @(posedge kClk);
    linkCmd <= '{lateN, 1'b1, m[0]};
    linkAddr <= ~a;
    dqIn <= d[0];
    @(posedge kClk);
    linkCmd <= '{1'b1, ~rw, m[1]};
    dqIn <= d[1];
    @(posedge kClkN);
    linkCmd.byteMaskN <= m[2];
    dqIn <= d[2];
    #40 q[0] = dqOut;
    @(posedge kClk);
    linkCmd.byteMaskN <= m[3];
    dqIn <= d[3];
    #40 q[1] = dqOut;
    @(posedge kClkN);
    linkCmd.byteMaskN <= ~m[3];
    dqIn <= ~d[3];
    #40 q[2] = dqOut;
    @(posedge kClk);
    #40 q[3] = dqOut;
  endtask
endmodule // dbs_ctrl_model

// >>> verification/dbs_sram_bus_asserts.sv
// Port checks for the burst static RAM bus block.
`timescale 1ns/1ps
module dbs_sram_bus_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire dbs_pkg::dbs_avs_req_s avsReq,
  input wire dbs_pkg::dbs_avs_rsp_s avsRsp,
  input wire logic kClk,
  input wire dbs_pkg::dbs_cmd_s linkCmd,
  input wire logic dqOeN
);
  import dbs_pkg::*;
  logic en;
  logic [1:0] ph;
  logic acc, accR, req, rdOk;
  assign req = avsReq.read || avsReq.write;
  assign rdOk = avsReq.read && !avsRsp.waitrequest;
  assign acc = en && !linkCmd.loadStrobeN && ph != 2'h1;
  assign accR = acc && linkCmd.readWriteN;
  always_ff @(posedge clk) begin
    if (reset) begin
      en <= 1'b0;
    end else if (avsReq.write && !avsRsp.waitrequest && avsReq.address == DBS_REG_CTRL) begin
      en <= avsReq.writedata[DBS_CTRL_EN_BIT];
    end
  end
  // A load in the first period of a burst is ignored, so the mirror must skip it.
  always_ff @(posedge kClk) begin
    if (reset) begin
      ph <= 2'h0;
    end else begin
      ph <= acc ? 2'h1 : {ph == 2'h1, 1'b0};
    end
  end
  a_read_drive: assert property (@(posedge kClk) disable iff (reset)
    accR |-> ##2 !dqOeN ##1 !dqOeN) else $error("Read burst not driven.");
  a_bus_cause: assert property (@(posedge kClk) disable iff (reset)
    !dqOeN |-> $past(accR, 2) || $past(accR, 3)) else $error("Bus driven without a read.");
  a_write_quiet: assert property (@(posedge kClk) disable iff (reset)
    acc && !linkCmd.readWriteN |-> ##2 dqOeN ##1 dqOeN) else $error("Bus driven in a write.");
  a_burst_end: assert property (@(posedge kClk) disable iff (reset)
    accR |-> ##4 (dqOeN || $past(accR, 2))) else $error("Read burst too long.");
  a_one_wait: assert property (@(posedge clk) disable iff (reset)
    req && avsRsp.waitrequest |=> !avsRsp.waitrequest) else $error("Second wait state.");
  a_wait_fresh: assert property (@(posedge clk) disable iff (reset)
    req && !avsRsp.waitrequest |=> !req || avsRsp.waitrequest) else $error("No wait state.");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
    rdOk && avsReq.address[1:0] != 2'h0 |-> avsRsp.readdata == 32'h0) else $error("Unmapped read not 0.");
  a_ctrl_upper: assert property (@(posedge clk) disable iff (reset)
    rdOk && avsReq.address == DBS_REG_CTRL |-> avsRsp.readdata[31:3] == 29'h0) else $error("Spare bits set.");
  c_read: cover property (@(posedge kClk) disable iff (reset) accR);
  c_write: cover property (@(posedge kClk) disable iff (reset) acc && !linkCmd.readWriteN);
  c_late: cover property (@(posedge kClk) disable iff (reset) ph == 2'h1 && !linkCmd.loadStrobeN);
endmodule // dbs_sram_bus_asserts

// >>> verification/dbs_sram_bus_bench.sv
// Self-checking bench: masked bursts at each width, wrap order, registers and refusals.
`timescale 1ns/1ps
module dbs_sram_bus_bench;
  import dbs_pkg::*;
  typedef struct packed {logic [1:0] w; logic [3:0] m; logic [7:0] a; logic [1:0] off; logic tied;} dbs_row_s;
  localparam dbs_row_s ROWS [5] = '{'{2'h0, 4'he, 8'h10, 2'h1, 1'b1}, '{2'h0, 4'hd, 8'h22, 2'h2, 1'b1},
    '{2'h1, 4'h0, 8'h37, 2'h3, 1'b1}, '{2'h2, 4'he, 8'h44, 2'h2, 1'b0}, '{2'h3, 4'ha, 8'hfd, 2'h3, 1'b0}};
  logic clk, reset, tied, kClk, kClkN, cClk, cClkN, dqOeN;
  dbs_avs_req_s avsReq;
  dbs_avs_rsp_s avsRsp;
  dbs_cmd_s linkCmd;
  logic [7:0] linkAddr;
  logic [35:0] dqIn, dqOut, e;
  logic [35:0] p[4], d[4], q[4];
  logic [3:0] full[4], mk[4];
  logic [31:0] r;
  dbs_row_s row;
  int bad_count, comparisons, k;
  dbs_sram_bus #(.ADDR_W(8)) uut (.clk(clk), .reset(reset), .avsReq(avsReq), .avsRsp(avsRsp), .kClk(kClk),
    .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN), .linkCmd(linkCmd), .linkAddr(linkAddr), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN));
  dbs_ctrl_model ctrl (.tied(tied), .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN),
    .linkCmd(linkCmd), .linkAddr(linkAddr), .dqIn(dqIn), .dqOut(dqOut));
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avsReq <= '{!w, w, a, wd};
    do begin
      @(posedge clk);
      n++;
    end while (avsRsp.waitrequest !== 1'b0 && n < 50);
    if (avsRsp.waitrequest !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    rd = avsRsp.readdata;
    avsReq <= '{1'b0, 1'b0, a, wd};
  endtask
  task automatic reg_is(input logic [3:0] a, input logic [31:0] exp);
    av(1'b0, a, 32'h0, r);
    check("register", 36'(r), 36'(exp));
  endtask
  function automatic logic [35:0] lanes(input logic [1:0] w, input logic [3:0] m);
    case (w)
      2'h0: lanes = {28'h0, {4{~m[1]}}, {4{~m[0]}}};
      2'h1: lanes = {27'h0, {9{~m[0]}}};
      2'h2: lanes = {18'h0, {9{~m[1]}}, {9{~m[0]}}};
      default: lanes = {{9{~m[3]}}, {9{~m[2]}}, {9{~m[1]}}, {9{~m[0]}}};
    endcase
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    tied = 1'b1;
    avsReq = '0;
    repeat (12) @(posedge clk);
    repeat (3) @(posedge kClk);
    @(posedge clk);
    reset <= 1'b0;
    foreach (ROWS[i]) begin
      row = ROWS[i];
      av(1'b1, DBS_REG_CTRL, {29'h0, row.w, 1'b1}, r);
      tied <= row.tied;
      for (int b = 0; b < 4; b++) begin
        p[b] = {4'(b), 32'h0f1e2d3c} ^ {8'(i), 28'h0};
        d[b] = ~p[b] ^ 36'(b * 3);
        full[b] = 4'h0;
        mk[b] = b < 2 ? row.m : (b == 2 ? 4'hf : 4'h0);
      end
      ctrl.burst(1'b0, 1'b1, row.a, p, full, q);
      ctrl.burst(1'b0, 1'b1, row.a, d, mk, q);
      ctrl.burst(1'b1, 1'b1, {row.a[7:2], row.off}, d, full, q);
      for (int j = 0; j < 4; j++) begin
        k = (int'(row.off) + j - int'(row.a[1:0])) & 3;
        e = (p[k] & ~lanes(row.w, mk[k])) | (d[k] & lanes(row.w, mk[k]));
        check("read beat", q[j] & lanes(row.w, 4'h0), e & lanes(row.w, 4'h0));
      end
      reg_is(DBS_REG_STATUS, {31'h0, row.tied});
    end
    repeat (2) @(posedge kClk);
    reg_is(DBS_REG_WRCOUNT, 32'ha);
    reg_is(DBS_REG_RDCOUNT, 32'h5);
    av(1'b1, DBS_REG_WRCOUNT, 32'h0, r);
    av(1'b1, DBS_REG_RDCOUNT, 32'h0, r);
    ctrl.burst(1'b0, 1'b0, 8'h80, p, full, q);
    repeat (2) @(posedge kClk);
    reg_is(DBS_REG_WRCOUNT, 32'h1);
    reg_is(DBS_REG_RDCOUNT, 32'h0);
    av(1'b1, DBS_REG_CTRL, 32'h6, r);
    ctrl.burst(1'b1, 1'b1, 8'h80, p, full, q);
    repeat (2) @(posedge kClk);
    reg_is(DBS_REG_RDCOUNT, 32'h0);
    av(1'b1, 4'h2, 32'hffffffff, r);
    reg_is(4'h2, 32'h0);
    reg_is(DBS_REG_CTRL, 32'h6);
    av(1'b1, DBS_REG_CTRL, 32'h1, r);
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge kClk);
    @(posedge clk);
    reset <= 1'b0;
    reg_is(DBS_REG_CTRL, 32'(DBS_CTRL_RESET));
    reg_is(DBS_REG_WRCOUNT, 32'h0);
    give_verdict();
  end
endmodule // dbs_sram_bus_bench
bind dbs_sram_bus dbs_sram_bus_asserts chk (.clk(clk), .reset(reset), .avsReq(avsReq), .avsRsp(avsRsp),
  .kClk(kClk), .linkCmd(linkCmd), .dqOeN(dqOeN));

// >>> verilog/dbs_pkg.sv
// Constants and carrier types of the four-beat burst static RAM bus block.
package dbs_pkg;

  localparam int DBS_DQ_W = 36;
  localparam int DBS_ADDR_W_DEF = 8;
  localparam int DBS_BEATS = 4;
  localparam int DBS_LANE_W = 9;
  localparam int DBS_NIBBLE_W = 4;
  localparam int DBS_MASK_W = 4;
  localparam int DBS_SYNC_STAGES = 2;

  localparam logic [3:0] DBS_REG_CTRL = 4'h0;
  localparam logic [3:0] DBS_REG_STATUS = 4'h4;
  localparam logic [3:0] DBS_REG_WRCOUNT = 4'h8;
  localparam logic [3:0] DBS_REG_RDCOUNT = 4'hc;

  localparam int DBS_CTRL_EN_BIT = 0;
  localparam int DBS_CTRL_WIDTH_LSB = 1;
  localparam int DBS_CTRL_W = 3;
  localparam logic [2:0] DBS_CTRL_RESET = 3'h6;
  localparam int DBS_STATUS_TIED_BIT = 0;
  localparam int DBS_STATUS_BUSY_BIT = 1;
  localparam int DBS_COUNT_W = 16;

  typedef enum logic [1:0] {
    DBS_X8,
    DBS_X9,
    DBS_X18,
    DBS_X36
  } dbs_width_e;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_WR1,
    PH_WR2,
    PH_RD1,
    PH_RD2
  } dbs_phase_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } dbs_avs_req_s;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } dbs_avs_rsp_s;

  typedef struct packed {
    logic loadStrobeN;
    logic readWriteN;
    logic [DBS_MASK_W-1:0] byteMaskN;
  } dbs_cmd_s;

endpackage

// >>> verilog/dbs_sram_bus.sv
// Device side of a double-data-rate static RAM bus with four-beat bursts.
// Function
// (R1) Low two address bits advance, wrapping modulo four.
// (R2) Every access is a fixed four-beat burst.
// (R3) Write beats taken at K and /K, t+1, t+2.
// (R4) Read beats driven at /C t+1 through C t+3.
// (R5) Load low starts access; load high is idle.
// (R6) Control inputs sampled on input clock rise only.
// (R7) Write data registered on both input clocks.
// (R8) Output clocks launch data; tied high uses K.
// (R9) Data bus stays high-impedance until enabled.
// (R10) Controller should stop all clocks at one level.
// (R11) On x8, two nibble masks gate each beat.
// (R12) On x9, one byte mask gates each beat.
// (R13) On x18, two byte masks gate each beat.
// (R14) On x36, four byte masks gate each beat.
// (R15) Tied output clocks must stay high always.
// (R16) Each access holds the bus two clock periods.
`timescale 1ns/1ps

module dbs_sram_bus #(
  parameter int ADDR_W = dbs_pkg::DBS_ADDR_W_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire dbs_pkg::dbs_avs_req_s avsReq,
  output dbs_pkg::dbs_avs_rsp_s avsRsp,
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic cClk,
  input wire logic cClkN,
  input wire dbs_pkg::dbs_cmd_s linkCmd,
  input wire logic [ADDR_W-1:0] linkAddr,
  input wire logic [dbs_pkg::DBS_DQ_W-1:0] dqIn,
  output logic [dbs_pkg::DBS_DQ_W-1:0] dqOut,
  output logic dqOeN
);
  import dbs_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [DBS_CTRL_W-1:0] ctrl;
    logic [DBS_COUNT_W-1:0] wrCount;
    logic [DBS_COUNT_W-1:0] rdCount;
    logic [2:0] wrTglSync;
    logic [2:0] rdTglSync;
    logic [DBS_SYNC_STAGES-1:0] tiedSync;
    logic [DBS_SYNC_STAGES-1:0] busySync;
  } dbs_sys_s;

  typedef struct packed {
    logic [DBS_SYNC_STAGES-1:0] rstPipe;
    logic [DBS_CTRL_W-1:0] ctrlS1;
    logic [DBS_CTRL_W-1:0] ctrlS2;
    logic [1:0] cS1;
    logic [1:0] cS2;
    logic tied;
    dbs_phase_e phase;
    logic [ADDR_W-1:0] base;
    logic wrTail;
    logic [ADDR_W-1:0] tailAddr;
    logic riseReq;
    logic [ADDR_W-1:0] riseAddr;
    logic [DBS_DQ_W-1:0] fallWord;
    logic fallValid;
    logic wrTgl;
    logic rdTgl;
  } dbs_link_s;

  typedef struct packed {
    logic [DBS_DQ_W-1:0] data;
    logic [DBS_MASK_W-1:0] mask;
    logic [DBS_DQ_W-1:0] riseWord;
    logic riseValid;
  } dbs_half_s;

  typedef struct packed {
    logic [DBS_DQ_W-1:0] q;
    logic oe;
  } dbs_out_s;

  localparam int DEPTH = 2 ** ADDR_W;

  dbs_sys_s sys;
  dbs_sys_s next_sys;
  dbs_link_s lnk;
  dbs_link_s next_lnk;
  dbs_half_s half;
  dbs_half_s next_half;
  dbs_out_s riseOut;
  dbs_out_s next_riseOut;
  dbs_out_s fallOut;
  dbs_out_s next_fallOut;
  logic [DBS_DQ_W-1:0] mem [DEPTH];
  logic p0En;
  logic [ADDR_W-1:0] p0Addr;
  logic [DBS_DQ_W-1:0] p0Data;
  logic [DBS_DQ_W-1:0] p0Mask;
  logic p1En;
  logic [ADDR_W-1:0] p1Addr;
  logic [DBS_DQ_W-1:0] p1Data;
  logic [DBS_DQ_W-1:0] p1Mask;
  logic kRst;
  logic linkEn;
  dbs_width_e width;
  logic outClk;
  logic outClkN;

  // Address of burst beat i: only the two low bits advance.
  // The upper bits never carry, so a burst stays inside its aligned group of four words.
  function automatic logic [ADDR_W-1:0] beatAddr(input logic [ADDR_W-1:0] base, input int i);
    beatAddr = {base[ADDR_W-1:2], base[1:0] + 2'(i)}; // (R1)
  endfunction

  // Per-bit write enable from the active-low masks of one beat.
  function automatic logic [DBS_DQ_W-1:0] laneEnable(input dbs_width_e w, input logic [DBS_MASK_W-1:0] mN);
    logic [DBS_DQ_W-1:0] e;
    e = '0;
    unique case (w)
      DBS_X8: begin
        e[0 +: DBS_NIBBLE_W] = {DBS_NIBBLE_W{~mN[0]}}; // (R11)
        e[DBS_NIBBLE_W +: DBS_NIBBLE_W] = {DBS_NIBBLE_W{~mN[1]}}; // (R11)
      end
      DBS_X9: e[0 +: DBS_LANE_W] = {DBS_LANE_W{~mN[0]}}; // (R12)
      DBS_X18: begin
        for (int i = 0; i < 2; i++) begin
          e[i*DBS_LANE_W +: DBS_LANE_W] = {DBS_LANE_W{~mN[i]}}; // (R13)
        end
      end
      DBS_X36: begin
        for (int i = 0; i < DBS_MASK_W; i++) begin
          e[i*DBS_LANE_W +: DBS_LANE_W] = {DBS_LANE_W{~mN[i]}}; // (R14)
        end
      end
    endcase
    return e;
  endfunction

  // Register slave on the system clock.
  // Every access takes exactly one wait state, which keeps read data registered.
  assign avsRsp.waitrequest = (avsReq.read | avsReq.write) & ~sys.ack;
  assign avsRsp.readdata = sys.rdata;

  always_comb begin
    next_sys = sys;
    next_sys.ack = (avsReq.read | avsReq.write) & ~sys.ack;
    next_sys.wrTglSync = {sys.wrTglSync[1:0], lnk.wrTgl};
    next_sys.rdTglSync = {sys.rdTglSync[1:0], lnk.rdTgl};
    next_sys.tiedSync = {sys.tiedSync[0], lnk.tied};
    next_sys.busySync = {sys.busySync[0], lnk.phase != PH_IDLE || lnk.wrTail};
    if (avsReq.read && !sys.ack) begin
      next_sys.rdata = '0;
      unique case (avsReq.address)
        DBS_REG_CTRL: next_sys.rdata[DBS_CTRL_W-1:0] = sys.ctrl;
        DBS_REG_STATUS: begin
          next_sys.rdata[DBS_STATUS_TIED_BIT] = sys.tiedSync[1];
          next_sys.rdata[DBS_STATUS_BUSY_BIT] = sys.busySync[1];
        end
        DBS_REG_WRCOUNT: next_sys.rdata[DBS_COUNT_W-1:0] = sys.wrCount;
        DBS_REG_RDCOUNT: next_sys.rdata[DBS_COUNT_W-1:0] = sys.rdCount;
        default: next_sys.rdata = '0;
      endcase
    end
    // A clear and a completed burst in the same cycle leave a count of one.
    if (avsReq.write && sys.ack) begin
      unique case (avsReq.address)
        DBS_REG_CTRL: next_sys.ctrl = avsReq.writedata[DBS_CTRL_W-1:0];
        DBS_REG_WRCOUNT: next_sys.wrCount = '0;
        DBS_REG_RDCOUNT: next_sys.rdCount = '0;
        default: next_sys.ctrl = sys.ctrl;
      endcase
    end
    if (sys.wrTglSync[2] != sys.wrTglSync[1]) begin
      next_sys.wrCount = next_sys.wrCount + DBS_COUNT_W'(1);
    end
    if (sys.rdTglSync[2] != sys.rdTglSync[1]) begin
      next_sys.rdCount = next_sys.rdCount + DBS_COUNT_W'(1);
    end
    if (reset) begin
      next_sys = '0;
      next_sys.ctrl = DBS_CTRL_RESET;
    end
  end

  always_ff @(posedge clk) begin
    sys <= next_sys;
  end

  // Link logic on the rising edge of K.
  assign kRst = lnk.rstPipe[1];
  assign linkEn = lnk.ctrlS2[DBS_CTRL_EN_BIT];
  assign width = dbs_width_e'(lnk.ctrlS2[DBS_CTRL_WIDTH_LSB +: 2]);

  always_comb begin
    next_lnk = lnk;
    p0En = 1'b0;
    p0Addr = '0;
    p0Data = '0;
    p0Mask = '0;
    p1En = 1'b0;
    p1Addr = '0;
    p1Data = '0;
    p1Mask = '0;
    next_lnk.rstPipe = {lnk.rstPipe[0], reset};
    // The control word is quasi-static, so two flops per bit are enough.
    next_lnk.ctrlS1 = sys.ctrl;
    next_lnk.ctrlS2 = lnk.ctrlS1;
    next_lnk.cS1 = {cClk, cClkN};
    next_lnk.cS2 = lnk.cS1;
    next_lnk.tied = &lnk.cS2; // (R8) (R15)
    next_lnk.wrTail = 1'b0;
    next_lnk.riseReq = 1'b0;
    next_lnk.fallValid = 1'b0;
    if (lnk.wrTail) begin
      p1En = 1'b1;
      p1Addr = lnk.tailAddr;
      p1Data = half.data; // (R7)
      p1Mask = laneEnable(width, half.mask);
      next_lnk.wrTgl = ~lnk.wrTgl;
    end
    unique case (lnk.phase)
      PH_IDLE: next_lnk.phase = PH_IDLE;
      PH_WR1: begin
        p0En = 1'b1; // (R3)
        p0Addr = beatAddr(lnk.base, 0);
        p0Data = dqIn;
        p0Mask = laneEnable(width, linkCmd.byteMaskN);
        next_lnk.phase = PH_WR2;
      end
      PH_WR2: begin
        p0En = 1'b1; // (R3)
        p0Addr = beatAddr(lnk.base, 1);
        p0Data = half.data; // (R7)
        p0Mask = laneEnable(width, half.mask);
        p1En = 1'b1;
        p1Addr = beatAddr(lnk.base, 2);
        p1Data = dqIn;
        p1Mask = laneEnable(width, linkCmd.byteMaskN);
        next_lnk.wrTail = 1'b1;
        next_lnk.tailAddr = beatAddr(lnk.base, 3);
        next_lnk.phase = PH_IDLE; // (R2)
      end
      PH_RD1: begin
        next_lnk.fallWord = mem[beatAddr(lnk.base, 0)]; // (R4)
        next_lnk.fallValid = 1'b1;
        next_lnk.riseAddr = beatAddr(lnk.base, 1);
        next_lnk.riseReq = 1'b1;
        next_lnk.phase = PH_RD2;
      end
      PH_RD2: begin
        next_lnk.fallWord = mem[beatAddr(lnk.base, 2)]; // (R4)
        next_lnk.fallValid = 1'b1;
        next_lnk.riseAddr = beatAddr(lnk.base, 3);
        next_lnk.riseReq = 1'b1;
        next_lnk.rdTgl = ~lnk.rdTgl;
        next_lnk.phase = PH_IDLE; // (R2)
      end
      // An illegal phase code falls back to idle rather than hang the bus.
      default: next_lnk.phase = PH_IDLE;
    endcase
    // A new load is taken only where the previous burst frees the bus.
    if ((lnk.phase == PH_IDLE || lnk.phase == PH_WR2 || lnk.phase == PH_RD2) && linkEn
        && !linkCmd.loadStrobeN) begin // (R5) (R6) (R16)
      next_lnk.base = linkAddr;
      next_lnk.phase = linkCmd.readWriteN ? PH_RD1 : PH_WR1; // (R5)
    end
    if (kRst) begin
      next_lnk = '0;
      next_lnk.rstPipe = {lnk.rstPipe[0], reset};
      next_lnk.ctrlS1 = sys.ctrl;
      next_lnk.phase = PH_IDLE;
    end
  end

  always_ff @(posedge kClk) begin
    lnk <= next_lnk;
  end

  // Two write ports; beats of one burst never share an address.
  // Two ports let the middle two beats land in one K period, so the next burst finds them written.
  always_ff @(posedge kClk) begin
    if (p0En) begin
      mem[p0Addr] <= (mem[p0Addr] & ~p0Mask) | (p0Data & p0Mask);
    end
    if (p1En) begin
      mem[p1Addr] <= (mem[p1Addr] & ~p1Mask) | (p1Data & p1Mask);
    end
  end

  // The /K half captures odd write beats and stages odd read beats.
  always_comb begin
    next_half = half;
    next_half.data = dqIn; // (R7)
    next_half.mask = linkCmd.byteMaskN;
    next_half.riseValid = lnk.riseReq;
    if (lnk.riseReq) begin
      next_half.riseWord = mem[lnk.riseAddr]; // (R4)
    end
    if (kRst) begin
      next_half = '0;
    end
  end

  always_ff @(posedge kClkN) begin
    half <= next_half;
  end

  // The output reference follows C, or K while both output clocks sit high.
  // Changing between the two modes while a read is out can clip a beat.
  // The controller must therefore change the output clock mode only while the bus is idle.
  assign outClk = lnk.tied ? kClk : cClk; // (R8)
  assign outClkN = lnk.tied ? kClkN : cClkN; // (R8)

  always_comb begin
    next_fallOut.q = lnk.fallWord;
    next_fallOut.oe = lnk.fallValid & linkEn; // (R9)
    next_riseOut.q = half.riseWord;
    next_riseOut.oe = half.riseValid & linkEn; // (R9)
    if (kRst) begin
      next_fallOut = '0;
      next_riseOut = '0;
    end
  end

  always_ff @(posedge outClkN) begin
    fallOut <= next_fallOut;
  end

  always_ff @(posedge outClk) begin
    riseOut <= next_riseOut;
  end

  // Each flop is shown in the half period that follows its own edge.
  // Until the first output clock edges after reset the bus value is not defined.
  // Controllers must hold reset across a few link clock edges before they rely on it.
  assign dqOut = outClk ? riseOut.q : fallOut.q; // (R4)
  assign dqOeN = ~(outClk ? riseOut.oe : fallOut.oe); // (R5) (R9)

endmodule // dbs_sram_bus
